// [rtl/afhp_device.sv]
// device end: byte fifo port with tx capture and rx frame delivery
// How it works
// - host requests only when tx busy low
// - host never requests while rx valid
// - busy rises after host transmit request
// - one byte captured per write strobe rise
// - host drops request after final byte
// - write strobe at most 16 of 20 MHz
// - rx valid after gap, only when idle
// - no receive start during transmit
// - receive buffer holds 2 KB
// - one new byte per read strobe rise
// - frame starts with length, high first
// - rx valid drops after final byte read
// - drive bus only on read and select
// - select high floats every port output
// - strobes sampled on reference clock
// - error flag marks a bad received frame
// - busy held until ready, may re-rise
module afhp_device #(
    parameter int unsigned RX_DEPTH = afhp_pkg::RX_BUF_BYTES,
    parameter int unsigned TX_DEPTH = afhp_pkg::TX_BUF_BYTES
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // pins
    afhp_if.device           port,
    // receive source: one frame loaded byte by byte
    input  wire logic        rx_load_valid,
    input  wire logic [7:0]  rx_load_byte,
    input  wire logic        rx_load_last,
    input  wire logic        rx_load_error,
    output logic             rx_load_ready,
    // transmit sink
    output logic             tx_out_valid,
    output logic [7:0]       tx_out_byte,
    input  wire logic        tx_out_ready
);
    localparam int unsigned RA = $clog2(RX_DEPTH);
    localparam int unsigned TA = $clog2(TX_DEPTH);

    typedef enum logic [1:0] {RX_FILL, RX_GAP, RX_SEND} afhp_rxst_t;

    typedef struct packed {
        logic [2:0]    wr_sync;
        logic [2:0]    rd_sync;
        logic [2:0]    txr_sync;
        logic [2:0]    cs_sync;
        logic          wr_lvl;
        logic          rd_lvl;
        logic          txr_lvl;
        logic          cs_lvl;
        logic          busy;
        logic [TA:0]   tx_cnt;
        logic [TA-1:0] tx_wp;
        logic [TA-1:0] tx_rp;
        afhp_rxst_t    rxst;
        logic [RA:0]   rx_len;
        logic [RA:0]   rx_idx;
        logic [15:0]   gap;
        logic          rxv;
        logic          rxe;
        logic          rx_err_pend;
        logic [7:0]    dout;
        logic          doe;
        logic          ooe;
        logic          txv;
        logic [7:0]    txb;
    } afhp_dev_st_t;

    afhp_dev_st_t st_q;
    afhp_dev_st_t st_d;
    logic [7:0]   rx_mem [RX_DEPTH];
    logic [7:0]   tx_mem [TX_DEPTH];
    logic         wr_rise;
    logic         rd_rise;
    logic         fill_en;
    logic [7:0]   rx_byte;
    logic [15:0]  len16;

    assign fill_en = st_q.rxst == RX_FILL && rx_load_valid
                     && st_q.rx_len < (RA+1)'(RX_DEPTH);
    assign len16   = 16'(st_q.rx_len);

    // second and third stage agree before a change counts
    always_comb
    begin
        st_d = st_q;
        st_d.wr_sync  = {st_q.wr_sync[1:0], port.write_strobe_n};
        st_d.rd_sync  = {st_q.rd_sync[1:0], port.read_strobe_n};
        st_d.txr_sync = {st_q.txr_sync[1:0], port.host_tx_request};
        st_d.cs_sync  = {st_q.cs_sync[1:0], port.port_select_n};
        if (st_q.wr_sync[2] == st_q.wr_sync[1])
            st_d.wr_lvl = st_q.wr_sync[2];
        if (st_q.rd_sync[2] == st_q.rd_sync[1])
            st_d.rd_lvl = st_q.rd_sync[2];
        if (st_q.txr_sync[2] == st_q.txr_sync[1])
            st_d.txr_lvl = st_q.txr_sync[2];
        if (st_q.cs_sync[2] == st_q.cs_sync[1])
            st_d.cs_lvl = st_q.cs_sync[2];
        wr_rise = st_d.wr_lvl && !st_q.wr_lvl;
        rd_rise = st_d.rd_lvl && !st_q.rd_lvl;

        // transmit side
        if (st_q.txr_lvl)
            st_d.busy = 1'b1;
        else if (st_q.tx_cnt == '0 && !st_q.txv)
            st_d.busy = 1'b0;
        if (st_q.txv && tx_out_ready)
            st_d.txv = 1'b0;
        if (!st_d.txv && st_q.tx_cnt != '0)
        begin
            st_d.txv   = 1'b1;
            st_d.txb   = tx_mem[st_q.tx_rp];
            st_d.tx_rp = st_q.tx_rp + 1'b1;
        end
        if (st_q.txr_lvl && wr_rise && !st_q.cs_lvl
            && st_q.tx_cnt < (TA+1)'(TX_DEPTH))
            st_d.tx_wp = st_q.tx_wp + 1'b1;
        st_d.tx_cnt = st_q.tx_cnt
                      + (TA+1)'(st_d.tx_wp != st_q.tx_wp)
                      - (TA+1)'(st_d.tx_rp != st_q.tx_rp);

        // receive side
        rx_byte = 8'h00;
        case (st_q.rxst)
            RX_FILL:
            begin
                // a full buffer drops bytes but still ends the frame
                if (rx_load_valid)
                begin
                    if (fill_en)
                        st_d.rx_len = st_q.rx_len + 1'b1;
                    if (rx_load_error)
                        st_d.rx_err_pend = 1'b1;
                    if (rx_load_last)
                    begin
                        st_d.rxst = RX_GAP;
                        st_d.gap  = '0;
                    end
                end
            end
            RX_GAP:
            begin
                if (st_q.busy || st_q.txr_lvl)
                    st_d.gap = '0;
                else if (st_q.gap < 16'(afhp_pkg::IFG_CYCLES))
                    st_d.gap = st_q.gap + 16'h0001;
                else
                begin
                    st_d.rxst   = RX_SEND;
                    st_d.rxv    = 1'b1;
                    st_d.rxe    = st_q.rx_err_pend;
                    st_d.rx_idx = '0;
                    st_d.dout   = len16[15:8];
                end
            end
            RX_SEND:
            begin
                if (rd_rise && !st_q.cs_lvl)
                begin
                    // byte just read was rx_idx, present the next one
                    if (st_q.rx_idx == '0)
                        rx_byte = len16[7:0];
                    else
                        rx_byte = rx_mem[RA'(st_q.rx_idx - 1'b1)];
                    st_d.dout   = rx_byte;
                    st_d.rx_idx = st_q.rx_idx + 1'b1;
                    if (st_q.rx_idx == st_q.rx_len + 1'b1)
                    begin
                        st_d.rxv         = 1'b0;
                        st_d.rxe         = 1'b0;
                        st_d.dout        = afhp_pkg::BYTE_RESET;
                        st_d.rx_err_pend = 1'b0;
                        st_d.rx_len      = '0;
                        st_d.rxst        = RX_FILL;
                    end
                end
            end
            default: st_d.rxst = RX_FILL;
        endcase

        st_d.ooe = !st_d.cs_lvl;
        st_d.doe = !st_d.cs_lvl && !st_d.rd_lvl;
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            st_q        <= '0;
            st_q.wr_sync <= 3'h7;
            st_q.rd_sync <= 3'h7;
            st_q.cs_sync <= 3'h7;
            st_q.wr_lvl <= 1'b1;
            st_q.rd_lvl <= 1'b1;
            st_q.cs_lvl <= 1'b1;
            st_q.rxst   <= RX_FILL;
            st_q.dout   <= afhp_pkg::BYTE_RESET;
        end
        else
            st_q <= st_d;
    end

    // buffer writes kept out of reset
    always_ff @(posedge clock)
    begin
        if (fill_en)
            rx_mem[RA'(st_q.rx_len)] <= rx_load_byte;
        if (st_d.tx_wp != st_q.tx_wp)
            tx_mem[st_q.tx_wp] <= port.shared_byte_bus;
    end

    assign port.tx_in_progress = st_q.busy;
    assign port.rx_frame_valid = st_q.rxv;
    assign port.rx_error_flag  = st_q.rxe;
    assign port.outs_oe        = st_q.ooe;
    assign port.bus_dev_o      = st_q.dout;
    assign port.bus_dev_oe     = st_q.doe;
    assign rx_load_ready       = st_q.rxst == RX_FILL;
    assign tx_out_valid        = st_q.txv;
    assign tx_out_byte         = st_q.txb;
endmodule : afhp_device

// [rtl/afhp_host.sv]
// host end: strobes bytes in and out of the device port
module afhp_host (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // pins
    afhp_if.host             port,
    // user transmit side
    input  wire logic        send_valid,
    input  wire logic [7:0]  send_byte,
    input  wire logic        send_last,
    output logic             send_ready,
    // user receive side
    output logic             recv_valid,
    output logic [7:0]       recv_byte,
    output logic             recv_last,
    output logic             recv_error
);
    typedef enum logic [2:0] {H_IDLE, H_TXLO, H_TXHI, H_RXLO, H_RXHI}
        afhp_hst_t;

    typedef struct packed {
        logic [2:0] crs_s;
        logic [2:0] dv_s;
        logic [2:0] er_s;
        logic       crs;
        logic       dv;
        logic       er;
        afhp_hst_t  st;
        logic [3:0] cnt;
        logic       req;
        logic       wr_n;
        logic       rd_n;
        logic [7:0] dat;
        logic       doe;
        logic       last;
        logic       rdy;
        logic       rv;
        logic [7:0] rb;
        logic       rl;
        logic       re;
        logic       sel_n;
    } afhp_host_st_t;

    afhp_host_st_t s_q;
    afhp_host_st_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.crs_s = {s_q.crs_s[1:0], port.tx_in_progress};
        s_d.dv_s  = {s_q.dv_s[1:0], port.rx_frame_valid};
        s_d.er_s  = {s_q.er_s[1:0], port.rx_error_flag};
        if (s_q.crs_s[2] == s_q.crs_s[1])
            s_d.crs = s_q.crs_s[2];
        if (s_q.dv_s[2] == s_q.dv_s[1])
            s_d.dv = s_q.dv_s[2];
        if (s_q.er_s[2] == s_q.er_s[1])
            s_d.er = s_q.er_s[2];
        s_d.rdy = 1'b0;
        s_d.rv  = 1'b0;
        s_d.cnt = (s_q.cnt == 4'h0) ? 4'h0 : s_q.cnt - 4'h1;
        case (s_q.st)
            H_IDLE:
            begin
                s_d.rd_n = 1'b1;
                s_d.wr_n = 1'b1;
                if (s_q.dv && !s_q.req)
                begin
                    // low long enough for the device to sync and drive
                    s_d.st   = H_RXLO;
                    s_d.rd_n = 1'b0;
                    s_d.cnt  = 4'(afhp_pkg::STROBE_LOW_CYC) + 4'h6;
                end
                else if (send_valid && !s_q.dv && s_q.cnt == 4'h0
                         && (s_q.req || !s_q.crs))
                begin
                    s_d.req  = 1'b1;
                    s_d.dat  = send_byte;
                    s_d.last = send_last;
                    s_d.doe  = 1'b1;
                    s_d.rdy  = 1'b1;
                    s_d.wr_n = 1'b0;
                    s_d.st   = H_TXLO;
                    s_d.cnt  = 4'(afhp_pkg::STROBE_LOW_CYC)
                               + (s_q.req ? 4'h0 : 4'h6);
                end
            end
            H_TXLO:
                if (s_q.cnt == 4'h0)
                begin
                    s_d.wr_n = 1'b1;
                    s_d.st   = H_TXHI;
                    s_d.cnt  = 4'(afhp_pkg::STROBE_HIGH_CYC);
                end
            H_TXHI:
                if (s_q.cnt == 4'h0)
                begin
                    s_d.doe = 1'b0;
                    s_d.st  = H_IDLE;
                    if (s_q.last)
                    begin
                        s_d.req = 1'b0;
                        s_d.cnt = 4'(afhp_pkg::DRAIN_CYCLES);
                    end
                end
            H_RXLO:
                if (s_q.cnt == 4'h0)
                begin
                    s_d.rd_n = 1'b1;
                    s_d.rb   = port.shared_byte_bus;
                    s_d.re   = s_q.er;
                    s_d.st   = H_RXHI;
                    s_d.cnt  = 4'(afhp_pkg::DRAIN_CYCLES);
                end
            H_RXHI:
                if (s_q.cnt == 4'h0)
                begin
                    s_d.rv = 1'b1;
                    s_d.rl = !s_q.dv;
                    s_d.st = H_IDLE;
                end
            default: s_d.st = H_IDLE;
        endcase
        // select only while a transfer is under way
        s_d.sel_n = !(s_d.req || s_d.st != H_IDLE);
    end

    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            s_q       <= '0;
            s_q.st    <= H_IDLE;
            s_q.wr_n  <= 1'b1;
            s_q.rd_n  <= 1'b1;
            s_q.sel_n <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign port.host_tx_request = s_q.req;
    assign port.write_strobe_n  = s_q.wr_n;
    assign port.read_strobe_n   = s_q.rd_n;
    assign port.port_select_n   = s_q.sel_n;
    assign port.bus_host_o      = s_q.dat;
    assign port.bus_host_oe     = s_q.doe;
    assign send_ready           = s_q.rdy;
    assign recv_valid           = s_q.rv;
    assign recv_byte            = s_q.rb;
    assign recv_last            = s_q.rl;
    assign recv_error           = s_q.re;
endmodule : afhp_host

// [rtl/afhp_if.sv]
// pin bundle between the host and the device port
interface afhp_if;
    logic [7:0] bus_host_o;
    logic       bus_host_oe;
    logic [7:0] bus_dev_o;
    logic       bus_dev_oe;
    logic       host_tx_request;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       port_select_n;
    logic       tx_in_progress;
    logic       rx_frame_valid;
    logic       rx_error_flag;
    logic       outs_oe;
    logic [7:0] shared_byte_bus;

    assign shared_byte_bus = bus_dev_oe ? bus_dev_o :
                             bus_host_oe ? bus_host_o : 8'hFF;

    modport device (
        input  host_tx_request, write_strobe_n, read_strobe_n,
        input  port_select_n, shared_byte_bus,
        output tx_in_progress, rx_frame_valid, rx_error_flag, outs_oe,
        output bus_dev_o, bus_dev_oe
    );
    modport host (
        output host_tx_request, write_strobe_n, read_strobe_n,
        output port_select_n, bus_host_o, bus_host_oe,
        input  tx_in_progress, rx_frame_valid, rx_error_flag, outs_oe,
        input  shared_byte_bus
    );
endinterface : afhp_if

// [rtl/afhp_pkg.sv]
// shared constants for the fifo host port
package afhp_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned CLK_PERIOD_PS   = 50_000;
    localparam int unsigned IFG_PS          = 960_000;
    localparam int unsigned IFG_CYCLES      =
        (IFG_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RX_BUF_BYTES    = 2048;
    localparam int unsigned TX_BUF_BYTES    = 256;
    localparam int unsigned LEN_BYTES       = 2;
    localparam int unsigned STROBE_LOW_CYC  = 3;
    localparam int unsigned STROBE_HIGH_CYC = 3;
    localparam int unsigned DRAIN_CYCLES    = 8;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;
endpackage : afhp_pkg

// [testbench/afhp_bench.sv]
// self-checking bench joining host and device ends
module afhp_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        bit         rx;
        int         len;
        logic [7:0] base;
        bit         err;
    } afhp_row_t;
    localparam int LIMIT = 30000;
    logic       clock, reset_n;
    logic       ld_v, ld_last, ld_err, ld_rdy, to_v, to_rdy;
    logic       s_v, s_last, s_rdy, r_v, r_last, r_err, rx_err_q;
    logic [7:0] ld_b, to_b, s_b, r_b;
    int         err_total, checks, cyc, lasts;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    afhp_row_t  rows [6] = '{'{0, 1, 8'h10, 0}, '{0, 16, 8'h20, 0},
        '{1, 1, 8'h40, 0}, '{1, 12, 8'h70, 0}, '{1, 3, 8'hC0, 1},
        '{1, 260, 8'hE0, 0}};
    afhp_if afhp_if_inst ();
    afhp_device afhp_device_inst (.clock(clock), .reset_n(reset_n),
        .port(afhp_if_inst), .rx_load_valid(ld_v), .rx_load_byte(ld_b),
        .rx_load_last(ld_last), .rx_load_error(ld_err),
        .rx_load_ready(ld_rdy), .tx_out_valid(to_v), .tx_out_byte(to_b),
        .tx_out_ready(to_rdy));
    afhp_host afhp_host_inst (.clock(clock), .reset_n(reset_n),
        .port(afhp_if_inst), .send_valid(s_v), .send_byte(s_b),
        .send_last(s_last), .send_ready(s_rdy), .recv_valid(r_v),
        .recv_byte(r_b), .recv_last(r_last), .recv_error(r_err));
    afhp_chk afhp_chk_inst (.clock(clock), .reset_n(reset_n),
        .host_tx_request(afhp_if_inst.host_tx_request),
        .write_strobe_n(afhp_if_inst.write_strobe_n),
        .read_strobe_n(afhp_if_inst.read_strobe_n),
        .port_select_n(afhp_if_inst.port_select_n),
        .tx_in_progress(afhp_if_inst.tx_in_progress),
        .rx_frame_valid(afhp_if_inst.rx_frame_valid),
        .rx_error_flag(afhp_if_inst.rx_error_flag),
        .outs_oe(afhp_if_inst.outs_oe),
        .bus_dev_o(afhp_if_inst.bus_dev_o),
        .bus_dev_oe(afhp_if_inst.bus_dev_oe));
    initial
    begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    // collect bytes leaving both ends, cut a hang short
    always @(posedge clock)
    begin
        cyc++;
        if (to_v === 1'h1 && to_rdy === 1'h1)
            txq.push_back(to_b);
        if (r_v === 1'h1)
        begin
            rxq.push_back(r_b);
            rx_err_q = r_err;
            if (r_last === 1'h1)
                lasts++;
        end
        if (cyc == LIMIT)
        begin
            err_total++;
            close_out();
        end
    end
    task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8
    task automatic chk1(string what, logic exp, logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask : chk1
    task automatic tick(int n);
        repeat (n) @(posedge clock);
    endtask : tick
    task automatic send_frame(int len, logic [7:0] base);
        for (int i = 0; i < len; i++)
        begin
            s_v <= 1'h1;
            s_b <= base + 8'(i);
            s_last <= (i == len - 1);
            @(posedge clock);
            while (s_rdy !== 1'h1)
                @(posedge clock);
        end
        s_v <= 1'h0;
    endtask : send_frame
    task automatic load_frame(int len, logic [7:0] base, bit err);
        for (int i = 0; i < len; i++)
        begin
            ld_v <= 1'h1;
            ld_b <= base + 8'(i);
            ld_last <= (i == len - 1);
            ld_err <= err;
            @(posedge clock);
            while (ld_rdy !== 1'h1)
                @(posedge clock);
        end
        ld_v <= 1'h0;
    endtask : load_frame
    task automatic check_tx(int len, logic [7:0] base);
        while (txq.size() < len || afhp_if_inst.tx_in_progress !== 1'h0)
            @(posedge clock);
        chk8("tx count", 8'(len), 8'(txq.size()));
        for (int i = 0; i < len; i++)
            chk8("tx byte", base + 8'(i), txq[i]);
        txq.delete();
    endtask : check_tx
    task automatic check_rx(int len, logic [7:0] base, bit err);
        while (rxq.size() < len + 2)
            @(posedge clock);
        tick(4);
        chk8("rx count", 8'(len + 2), 8'(rxq.size()));
        chk8("rx len high", 8'(len >> 8), rxq[0]);
        chk8("rx len low", 8'(len), rxq[1]);
        for (int i = 0; i < len; i++)
            chk8("rx byte", base + 8'(i), rxq[i + 2]);
        chk1("rx valid", 1'h0, afhp_if_inst.rx_frame_valid);
        chk1("rx error", err, rx_err_q);
        chk8("rx last count", 8'h01, 8'(lasts));
        lasts = 0;
        rxq.delete();
    endtask : check_rx
    initial
    begin
        {reset_n, ld_v, ld_last, ld_err, s_v, s_last} <= 6'h00;
        {ld_b, s_b, to_rdy} <= {8'h00, 8'h00, 1'h1};
        tick(5);
        reset_n <= 1'h1;
        tick(2);
        chk1("dev drive", 1'h0, afhp_if_inst.bus_dev_oe);
        chk1("busy", 1'h0, afhp_if_inst.tx_in_progress);
        chk1("outs float", 1'h0, afhp_if_inst.outs_oe);
        foreach (rows[r])
        begin
            if (rows[r].rx)
            begin
                load_frame(rows[r].len, rows[r].base, rows[r].err);
                check_rx(rows[r].len, rows[r].base, rows[r].err);
            end
            else
            begin
                send_frame(rows[r].len, rows[r].base);
                check_tx(rows[r].len, rows[r].base);
            end
            $display("row %0d done", r);
        end
        // sink stalls: busy holds and rx waits behind tx
        to_rdy <= 1'h0;
        send_frame(4, 8'hA0);
        load_frame(2, 8'h50, 0);
        tick(40);
        chk1("busy held", 1'h1, afhp_if_inst.tx_in_progress);
        chk1("rx held", 1'h0, afhp_if_inst.rx_frame_valid);
        to_rdy <= 1'h1;
        check_tx(4, 8'hA0);
        check_rx(2, 8'h50, 0);
        $display("stall test done");
        // reset in mid frame, then a clean frame
        load_frame(6, 8'h60, 0);
        while (afhp_if_inst.rx_frame_valid !== 1'h1)
            @(posedge clock);
        tick(30);
        reset_n <= 1'h0;
        tick(3);
        chk1("rx valid", 1'h0, afhp_if_inst.rx_frame_valid);
        chk1("dev drive", 1'h0, afhp_if_inst.bus_dev_oe);
        reset_n <= 1'h1;
        rxq.delete();
        lasts = 0;
        tick(2);
        load_frame(3, 8'h30, 0);
        check_rx(3, 8'h30, 0);
        $display("reset test done");
        close_out();
    end
endmodule : afhp_bench

// [testbench/afhp_chk.sv]
// pin checker between host and device ends
module afhp_chk (
    // clock and reset
    input wire logic       clock,
    input wire logic       reset_n,
    // host side pins
    input wire logic       host_tx_request,
    input wire logic       write_strobe_n,
    input wire logic       read_strobe_n,
    input wire logic       port_select_n,
    // device side pins
    input wire logic       tx_in_progress,
    input wire logic       rx_frame_valid,
    input wire logic       rx_error_flag,
    input wire logic       outs_oe,
    input wire logic [7:0] bus_dev_o,
    input wire logic       bus_dev_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    localparam int unsigned GAP = afhp_pkg::IFG_CYCLES - 1;
    logic [15:0] idle_q;
    // cycles since busy was last high
    always_ff @(posedge clock)
    begin
        if (!reset_n || tx_in_progress)
            idle_q <= 16'h0000;
        else if (idle_q != 16'hFFFF)
            idle_q <= idle_q + 16'h0001;
    end
    property p_busy_ans;
        $rose(host_tx_request) |-> ##[1:8] tx_in_progress;
    endproperty
    a_busy_ans: assert property (p_busy_ans)
        else $error("busy missing after request");
    property p_busy_hold;
        tx_in_progress && host_tx_request |=> tx_in_progress;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped under request");
    property p_req_ok;
        $rose(host_tx_request) |-> !tx_in_progress && !rx_frame_valid;
    endproperty
    a_req_ok: assert property (p_req_ok)
        else $error("request raised at wrong time");
    property p_rx_gap;
        $rose(rx_frame_valid) |-> idle_q >= GAP;
    endproperty
    a_rx_gap: assert property (p_rx_gap)
        else $error("rx valid without idle gap");
    property p_drive_sel;
        port_select_n [*5] |-> !bus_dev_oe;
    endproperty
    a_drive_sel: assert property (p_drive_sel)
        else $error("bus driven without select");
    property p_quiet;
        read_strobe_n [*8] |-> !bus_dev_oe;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("bus driven with no read");
    property p_float;
        port_select_n [*5] |-> !outs_oe;
    endproperty
    a_float: assert property (p_float)
        else $error("outputs enabled while deselected");
    property p_wr_width;
        $fell(write_strobe_n) |-> (!write_strobe_n) [*3];
    endproperty
    a_wr_width: assert property (p_wr_width)
        else $error("write strobe too short");
    property p_err_valid;
        rx_error_flag |-> rx_frame_valid;
    endproperty
    a_err_valid: assert property (p_err_valid)
        else $error("error flag outside frame");
    property p_rd_hold;
        !read_strobe_n && !$past(read_strobe_n) |-> $stable(bus_dev_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read byte moved during strobe");
    c_rx: cover property ($rose(rx_frame_valid));
    c_tx: cover property ($fell(tx_in_progress));
    c_err: cover property ($rose(rx_error_flag));
endmodule : afhp_chk
